// ---- common/cwdeg_regs.svh ----
// How it works
// - each cycle is timed against the watchdog limit and an overrun gives fatal stop code 9f with a halt.
// - software may lengthen the watchdog limit at run time with the watchdog-extend instruction.
// - a cycle of 6,500 ms or longer always gives fatal stop 9f and a halt, whatever the extension.
// - a cycle of 100 ms or more sets the cycle-overrun flag and marks the 100 ms pulse unreliable.
// - the 20 ms pulse is unreliable from 20 ms cycles and the 200 ms pulse from 200 ms cycles.
// - from 10 ms cycles high-speed timers numbered 016 upward lose accuracy; the lowest group stays exact.
// - an online edit suspends the program for at most 80 ms with interrupts masked.
// - long-cycle warnings are suppressed while an edit rewrites the program.
// - with password 5a in the low byte and the lock bit set, edits are refused and held in standby.
// - the edit-wait flag stays set while an edit request is held in standby.
// - clearing the lock bit runs the pending edit and clears the edit-wait flag.
// - operator-terminal refresh takes 2.5 ms with empty tables and 5.4 ms at 32 strings and 128 numerals.
// - a 12-point output module is counted as a 16-point module for refresh time.
// - the watchdog restarts in the overseeing phase at each cycle start.
`ifndef CWDEG_REGS_SVH
`define CWDEG_REGS_SVH
// ============================================================
// register offsets (byte addresses)
`define CWDEG_ADDR_CTRL 6'h00
`define CWDEG_ADDR_WDT 6'h04
`define CWDEG_ADDR_EXT 6'h08
`define CWDEG_ADDR_STAT 6'h0c
`define CWDEG_ADDR_LAST 6'h10
`define CWDEG_ADDR_IRQ 6'h14
`define CWDEG_ADDR_MASK 6'h18
`define CWDEG_ADDR_PT 6'h1c
`define CWDEG_ADDR_TERM 6'h20
// ============================================================
// fields and codes
`define CWDEG_PASSWORD 8'h5a
`define CWDEG_LOCK_BIT 9
`define CWDEG_WAIT_BIT 10
`define CWDEG_FATAL_CODE 8'h9f
`define CWDEG_WDT_RESET 16'h0082
// ============================================================
// times in ms and ms tick
`define CWDEG_CLK_HZ 50000000
`define CWDEG_TICK_CYC (`CWDEG_CLK_HZ / 1000)
`define CWDEG_MS_MAX 6500
`define CWDEG_MS_ERR 100
`define CWDEG_MS_P20 20
`define CWDEG_MS_P200 200
`define CWDEG_MS_TIMH 10
`define CWDEG_MS_EDIT 80
`define CWDEG_EDIT_CYC (`CWDEG_MS_EDIT * `CWDEG_TICK_CYC)
// terminal refresh in tenths of ms
`define CWDEG_PT_MIN 13'd25
`define CWDEG_PT_MAX 13'd54
`define CWDEG_PT_STR_MAX 32
`define CWDEG_PT_NUM_MAX 128
`define CWDEG_PTS_12 12
`define CWDEG_PTS_16 16
`endif

// ---- common/cwdeg_pkg.sv ----
`default_nettype none
package cwdeg_pkg;
    typedef enum logic [1:0] {
        CWDEG_RUN = 2'b00,
        CWDEG_EDIT = 2'b01,
        CWDEG_HALT = 2'b10
    } cwdeg_state_t;
endpackage
`default_nettype wire

// ---- core/cwdeg_top.sv ----
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cwdeg_regs.svh"
module cwdeg_top #(
    parameter int TICK_CYC = `CWDEG_TICK_CYC,
    parameter int EDIT_CYC = `CWDEG_EDIT_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // avalon-mm slave
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // cycle and edit events from the processor core
    input wire logic i_cycle_start,
    input wire logic i_wdt_extend,
    input wire logic [15:0] i_wdt_extend_ms,
    input wire logic i_edit_req,
    input wire logic i_edit_done,
    // status out
    output logic o_halt,
    output logic [7:0] o_fatal_stop_code,
    output logic o_cycle_overrun_flag,
    output logic o_pulse_20ms_bad,
    output logic o_pulse_100ms_bad,
    output logic o_pulse_200ms_bad,
    output logic o_timh_high_bad,
    output logic o_prog_suspend,
    output logic o_irq_mask,
    output logic o_edit_grant,
    output logic o_irq
);
    initial begin
        if (TICK_CYC < 1 || EDIT_CYC < 1) begin
            $error("cwdeg_top: tick and edit counts must be positive");
        end
    end

    // ============================================================
    // ms timebase and cycle counter
    logic [31:0] tick_cnt;
    logic ms_tick;
    logic [12:0] cyc_ms;
    logic [12:0] last_ms;
    logic [15:0] wdt_set;
    logic [15:0] wdt_limit;
    cwdeg_pkg::cwdeg_state_t state;
    logic [31:0] edit_cnt;
    logic suppress;

    assign ms_tick = (tick_cnt == 32'(TICK_CYC - 1));
    assign suppress = (state == cwdeg_pkg::CWDEG_EDIT);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt <= 32'h0;
        end else if (i_cycle_start || ms_tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // restart at each boundary in run state, keep last length
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc_ms <= 13'h0;
            last_ms <= 13'h0;
        end else if (i_cycle_start && state == cwdeg_pkg::CWDEG_RUN) begin
            last_ms <= cyc_ms;
            cyc_ms <= 13'h0;
        end else if (ms_tick && !suppress && cyc_ms != 13'h1fff) begin
            cyc_ms <= cyc_ms + 13'h1;
        end
    end

    // ============================================================
    // watchdog limit: software base plus run-time extension
    logic [15:0] wdt_ext;
    logic sw_ext_wr;
    assign sw_ext_wr = i_avs_write && !o_avs_waitrequest
        && i_avs_address == `CWDEG_ADDR_EXT;
    assign wdt_limit = wdt_set + wdt_ext;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wdt_ext <= 16'h0;
        end else if (i_wdt_extend) begin
            wdt_ext <= wdt_ext + i_wdt_extend_ms;
        end else if (sw_ext_wr) begin
            wdt_ext <= wdt_ext + i_avs_writedata[15:0];
        end
    end

    // ============================================================
    // fatal stop
    logic overrun;
    assign overrun = (state == cwdeg_pkg::CWDEG_RUN) &&
        ({3'h0, cyc_ms} > wdt_limit || cyc_ms >= 13'(`CWDEG_MS_MAX));

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_halt <= 1'b0;
            o_fatal_stop_code <= 8'h00;
        end else if (overrun) begin
            o_halt <= 1'b1;
            o_fatal_stop_code <= `CWDEG_FATAL_CODE;
        end
    end

    // ============================================================
    // long-cycle quality flags, from the running or last cycle
    logic [12:0] eval_ms;
    assign eval_ms = (cyc_ms > last_ms) ? cyc_ms : last_ms;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cycle_overrun_flag <= 1'b0;
            o_pulse_20ms_bad <= 1'b0;
            o_pulse_100ms_bad <= 1'b0;
            o_pulse_200ms_bad <= 1'b0;
            o_timh_high_bad <= 1'b0;
        end else if (!suppress) begin
            o_cycle_overrun_flag <= eval_ms >= 13'(`CWDEG_MS_ERR);
            o_pulse_100ms_bad <= eval_ms >= 13'(`CWDEG_MS_ERR);
            o_pulse_20ms_bad <= eval_ms >= 13'(`CWDEG_MS_P20);
            o_pulse_200ms_bad <= eval_ms >= 13'(`CWDEG_MS_P200);
            o_timh_high_bad <= eval_ms >= 13'(`CWDEG_MS_TIMH);
        end
    end

    // ============================================================
    // online edit gate
    logic [15:0] edit_ctrl;
    logic edit_pend;
    logic locked;
    assign locked = edit_ctrl[7:0] == `CWDEG_PASSWORD
        && edit_ctrl[`CWDEG_LOCK_BIT];

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edit_pend <= 1'b0;
        end else if (i_edit_req) begin
            edit_pend <= 1'b1;
        end else if (state == cwdeg_pkg::CWDEG_RUN && !locked) begin
            edit_pend <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= cwdeg_pkg::CWDEG_RUN;
            edit_cnt <= 32'h0;
        end else begin
            case (state)
                cwdeg_pkg::CWDEG_RUN: begin
                    if (overrun) begin
                        state <= cwdeg_pkg::CWDEG_HALT;
                    end else if (edit_pend && !locked) begin
                        state <= cwdeg_pkg::CWDEG_EDIT;
                        edit_cnt <= 32'h0;
                    end
                end
                cwdeg_pkg::CWDEG_EDIT: begin
                    edit_cnt <= edit_cnt + 32'h1;
                    // bounded: never suspend beyond the limit
                    if (i_edit_done || edit_cnt == 32'(EDIT_CYC - 1)) begin
                        state <= cwdeg_pkg::CWDEG_RUN;
                    end
                end
                cwdeg_pkg::CWDEG_HALT: state <= cwdeg_pkg::CWDEG_HALT;
                default: state <= cwdeg_pkg::CWDEG_RUN;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prog_suspend <= 1'b0;
            o_irq_mask <= 1'b0;
            o_edit_grant <= 1'b0;
        end else begin
            o_prog_suspend <= state == cwdeg_pkg::CWDEG_EDIT;
            o_irq_mask <= state == cwdeg_pkg::CWDEG_EDIT;
            o_edit_grant <= state == cwdeg_pkg::CWDEG_RUN && edit_pend
                && !locked && !overrun;
        end
    end

    // ============================================================
    // operator-terminal refresh estimate, tenths of ms
    logic [5:0] pt_str;
    logic [7:0] pt_num;
    logic [12:0] pt_time;
    logic [4:0] out_pts;
    logic [4:0] pt_pts_in;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pt_time <= `CWDEG_PT_MIN;
            out_pts <= 5'h0;
        end else begin
            // linear between the two end points
            pt_time <= `CWDEG_PT_MIN + 13'(((`CWDEG_PT_MAX - `CWDEG_PT_MIN)
                * 32'(pt_str + {1'b0, pt_num}))
                / (`CWDEG_PT_STR_MAX + `CWDEG_PT_NUM_MAX));
            out_pts <= (pt_pts_in == 5'(`CWDEG_PTS_12))
                ? 5'(`CWDEG_PTS_16) : pt_pts_in;
        end
    end

    // ============================================================
    // registers
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] ev;
    logic wr;
    logic rd;
    logic rd_ack;
    assign wr = i_avs_write && !o_avs_waitrequest;
    assign rd = i_avs_read && !rd_ack;
    assign ev = {3'h0, state == cwdeg_pkg::CWDEG_EDIT && edit_cnt == 32'h0,
        edit_pend && locked, overrun,
        // fires on the tick that brings the count to the limit
        !suppress && cyc_ms == 13'(`CWDEG_MS_ERR - 1) && ms_tick, 1'b0};

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edit_ctrl <= 16'h0;
            wdt_set <= `CWDEG_WDT_RESET;
            irq_mask <= 8'h0;
            pt_str <= 6'h0;
            pt_num <= 8'h0;
            pt_pts_in <= 5'h0;
        end else if (wr) begin
            case (i_avs_address)
                `CWDEG_ADDR_CTRL: edit_ctrl <= {6'h0, i_avs_writedata[9:0]};
                `CWDEG_ADDR_WDT: wdt_set <= i_avs_writedata[15:0];
                `CWDEG_ADDR_MASK: irq_mask <= i_avs_writedata[7:0];
                `CWDEG_ADDR_PT: begin
                    pt_str <= i_avs_writedata[5:0];
                    pt_num <= i_avs_writedata[15:8];
                end
                `CWDEG_ADDR_TERM: pt_pts_in <= i_avs_writedata[4:0];
                default: edit_ctrl <= edit_ctrl;
            endcase
        end
    end

    // set wins over write-one clear
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat <= 8'h0;
        end else if (wr && i_avs_address == `CWDEG_ADDR_IRQ) begin
            irq_stat <= (irq_stat & ~i_avs_writedata[7:0]) | ev;
        end else begin
            irq_stat <= irq_stat | ev;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // reads take one wait cycle; writes none
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_ack <= 1'b0;
            o_avs_readdata <= 32'h0;
        end else begin
            rd_ack <= rd;
            if (rd) begin
                case (i_avs_address)
                    `CWDEG_ADDR_CTRL: o_avs_readdata <= {16'h0, 5'h0,
                        edit_pend && locked, edit_ctrl[9:0]};
                    `CWDEG_ADDR_WDT: o_avs_readdata <= {16'h0, wdt_set};
                    `CWDEG_ADDR_EXT: o_avs_readdata <= {16'h0, wdt_ext};
                    `CWDEG_ADDR_STAT: o_avs_readdata <= {6'h0, state,
                        o_fatal_stop_code, 3'h0, o_timh_high_bad,
                        o_pulse_200ms_bad, o_pulse_100ms_bad,
                        o_pulse_20ms_bad, o_cycle_overrun_flag,
                        5'h0, o_halt, o_prog_suspend, edit_pend};
                    `CWDEG_ADDR_LAST: o_avs_readdata <= {3'h0, cyc_ms,
                        3'h0, last_ms};
                    `CWDEG_ADDR_IRQ: o_avs_readdata <= {24'h0, irq_stat};
                    `CWDEG_ADDR_MASK: o_avs_readdata <= {24'h0, irq_mask};
                    `CWDEG_ADDR_PT: o_avs_readdata <= {16'h0, pt_num,
                        2'h0, pt_str};
                    `CWDEG_ADDR_TERM: o_avs_readdata <= {11'h0, out_pts,
                        3'h0, pt_time};
                    default: o_avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    assign o_avs_waitrequest = i_avs_read && !rd_ack;
endmodule
`default_nettype wire

// ---- tb/cwdeg_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwdeg_props #(
    parameter int TICK_CYC = 4,
    parameter int EDIT_CYC = 20
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic o_halt,
    input wire logic [7:0] o_fatal_stop_code,
    input wire logic o_cycle_overrun_flag,
    input wire logic o_pulse_20ms_bad,
    input wire logic o_pulse_100ms_bad,
    input wire logic o_pulse_200ms_bad,
    input wire logic o_timh_high_bad,
    input wire logic o_prog_suspend,
    input wire logic o_irq_mask,
    input wire logic o_edit_grant
);
    int sus_cnt;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // length of the current suspension, bounded above
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n)
            sus_cnt <= 0;
        else
            sus_cnt <= o_prog_suspend ? sus_cnt + 1 : 0;
    end
    property p_halt_hold; o_halt |=> o_halt; endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt");
    property p_code; o_halt == (o_fatal_stop_code == 8'h9f); endproperty
    a_code: assert property (p_code) else $error("stop code");
    property p_mask; o_prog_suspend == o_irq_mask; endproperty
    a_mask: assert property (p_mask) else $error("irq mask");
    property p_len; sus_cnt <= EDIT_CYC + 2; endproperty
    a_len: assert property (p_len) else $error("edit too long");
    property p_ovr; o_cycle_overrun_flag == o_pulse_100ms_bad; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun flag");
    property p_lo; o_pulse_20ms_bad |-> o_timh_high_bad; endproperty
    a_lo: assert property (p_lo) else $error("timer flag");
    property p_hi; o_pulse_200ms_bad |-> o_pulse_100ms_bad; endproperty
    a_hi: assert property (p_hi) else $error("pulse flags");
    property p_frz;
        o_prog_suspend ##1 o_prog_suspend |-> $stable(o_pulse_20ms_bad);
    endproperty
    a_frz: assert property (p_frz) else $error("flag moved");
    property p_grant; o_edit_grant |-> ##[0:2] o_prog_suspend; endproperty
    a_grant: assert property (p_grant) else $error("no edit");
endmodule
bind cwdeg_top cwdeg_props #(.TICK_CYC(TICK_CYC), .EDIT_CYC(EDIT_CYC)) u_p (
    .i_core_clk, .i_arst_n, .o_halt, .o_fatal_stop_code,
    .o_cycle_overrun_flag, .o_pulse_20ms_bad, .o_pulse_100ms_bad,
    .o_pulse_200ms_bad, .o_timh_high_bad, .o_prog_suspend, .o_irq_mask,
    .o_edit_grant
);
`default_nettype wire

// ---- tb/cwdeg_prog_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
// programming device: asks once, ends the rewrite after i_delay cycles
module cwdeg_prog_dev (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_ask,
    input wire logic [7:0] i_delay,
    input wire logic i_suspend,
    output logic o_edit_req,
    output logic o_edit_done
);
    logic [7:0] cnt;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt <= 8'h00;
            o_edit_req <= 1'b0;
            o_edit_done <= 1'b0;
        end else begin
            // no retry: the device must keep the request pending
            o_edit_req <= i_ask;
            cnt <= i_suspend ? cnt + 8'h01 : 8'h00;
            o_edit_done <= i_suspend && cnt == i_delay;
        end
    end
endmodule
`default_nettype wire

// ---- tb/cwdeg_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cwdeg_top_tb;
    localparam int TICK = 4;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [5:0] i_avs_address = 6'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic i_cycle_start = 1'b0;
    logic i_wdt_extend = 1'b0;
    logic [15:0] i_wdt_extend_ms = 16'h0;
    logic i_edit_req, i_edit_done, o_avs_waitrequest, o_halt, o_irq;
    logic o_cycle_overrun_flag, o_pulse_20ms_bad, o_pulse_100ms_bad;
    logic o_pulse_200ms_bad, o_timh_high_bad, o_prog_suspend;
    logic o_irq_mask, o_edit_grant, ask = 1'b0, saw = 1'b0;
    logic [7:0] o_fatal_stop_code, dly = 8'h03;
    logic [31:0] o_avs_readdata, q;
    int num_errors = 0, compares = 0, cyc = 0, seed = 90128, lim, m;
    int corner [6] = '{9, 10, 20, 100, 199, 200};
    always #10 i_core_clk = ~i_core_clk;
    cwdeg_top #(.TICK_CYC(TICK), .EDIT_CYC(20)) DUT (
        .i_core_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
        .i_cycle_start, .i_wdt_extend, .i_wdt_extend_ms, .i_edit_req,
        .i_edit_done, .o_halt, .o_fatal_stop_code, .o_cycle_overrun_flag,
        .o_pulse_20ms_bad, .o_pulse_100ms_bad, .o_pulse_200ms_bad,
        .o_timh_high_bad, .o_prog_suspend, .o_irq_mask, .o_edit_grant, .o_irq
    );
    cwdeg_prog_dev u_dev (
        .i_core_clk, .i_arst_n, .i_ask(ask), .i_delay(dly),
        .i_suspend(o_prog_suspend), .o_edit_req(i_edit_req),
        .o_edit_done(i_edit_done)
    );
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (o_prog_suspend === 1'b1)
            saw <= 1'b1;
        if (cyc == 60000) begin
            num_errors++;
            results();
        end
    end
    task automatic results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ends two edges late so a registered irq has caught up
    task automatic bus(input bit rd, input logic [5:0] a, logic [31:0] d);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= rd;
        i_avs_write <= !rd;
        // ends when o_avs_waitrequest drops; the bench timeout ends a hung wait
        do begin
            @(posedge i_core_clk);
        end while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic pulse(input bit ext, input logic [15:0] e);
        i_cycle_start <= !ext;
        i_wdt_extend <= ext;
        i_wdt_extend_ms <= e;
        @(posedge i_core_clk);
        i_cycle_start <= 1'b0;
        i_wdt_extend <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic run_ms(input int ms);
        pulse(0, 16'h0);
        repeat (ms * TICK) @(posedge i_core_clk);
        pulse(0, 16'h0);
    endtask
    task automatic edit(input logic [7:0] d);
        dly <= d;
        saw <= 1'b0;
        ask <= 1'b1;
        @(posedge i_core_clk);
        ask <= 1'b0;
        repeat (40) @(posedge i_core_clk);
    endtask
    function automatic logic [4:0] flags(input int ms);
        return {ms >= 10, ms >= 200, ms >= 100, ms >= 20, ms >= 100};
    endfunction
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        bus(1, 6'h04, 32'h0);
        chk(q, 32'h82);
        bus(1, 6'h3c, 32'h0);
        chk(q, 32'h0);
        lim = 130 + ($unsigned($random(seed)) % 32);
        pulse(1, 16'(lim - 130));
        bus(1, 6'h08, 32'h0);
        chk(q[15:0], lim - 130);
        for (int k = 0; k < 2; k++) begin
            bus(0, 6'h1c, k ? 32'h8020 : 32'h0);
            bus(0, 6'h20, 32'hc);
            bus(1, 6'h20, 32'h0);
            chk(q[12:0], k ? 32'h36 : 32'h19);
            chk(q[20:16], 32'h10);
        end
        // long cycles below must not trip the watchdog
        bus(0, 6'h04, 32'h3e8);
        for (int i = 0; i < 10; i++) begin
            m = i < 6 ? corner[i] : 1 + $unsigned($random(seed)) % 220;
            run_ms(m);
            bus(1, 6'h0c, 32'h0);
            chk(q[12:8], flags(m));
            chk({o_timh_high_bad, o_pulse_200ms_bad, o_pulse_100ms_bad,
                o_pulse_20ms_bad, o_cycle_overrun_flag}, flags(m));
            bus(1, 6'h10, 32'h0);
            chk(q[12:0], m);
            chk(q[28:17], 32'h0);
        end
        bus(0, 6'h04, 32'h82);
        bus(0, 6'h14, 32'h1e);
        run_ms(99);
        bus(1, 6'h14, 32'h0);
        chk(q[1], 32'h0);
        run_ms(100);
        run_ms(5);
        bus(1, 6'h14, 32'h0);
        chk(q[1], 32'h1);
        bus(0, 6'h18, 32'h2);
        chk(o_irq, 32'h1);
        bus(0, 6'h18, 32'h0);
        chk(o_irq, 32'h0);
        bus(0, 6'h14, 32'h2);
        bus(1, 6'h14, 32'h0);
        chk(q[1], 32'h0);
        for (int k = 0; k < 2; k++) begin
            bus(0, 6'h00, k ? 32'h25a : 32'h200);
            edit(8'h03);
            bus(1, 6'h00, 32'h0);
            chk(q[10], k);
            chk(saw, !k);
        end
        bus(0, 6'h00, 32'h5a);
        repeat (12) @(posedge i_core_clk);
        bus(1, 6'h00, 32'h0);
        chk(q[10], 32'h0);
        chk(saw, 32'h1);
        edit(8'hc8);
        chk(o_prog_suspend, 32'h0);
        pulse(0, 16'h0);
        repeat (lim * TICK - 4) @(posedge i_core_clk);
        chk(o_halt, 32'h0);
        repeat (3 * TICK) @(posedge i_core_clk);
        chk({o_halt, o_fatal_stop_code}, 32'h19f);
        i_arst_n <= 1'b0;
        repeat (16) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        pulse(1, 16'h1f40);
        pulse(0, 16'h0);
        repeat (6500 * TICK - 8) @(posedge i_core_clk);
        chk(o_halt, 32'h0);
        repeat (3 * TICK) @(posedge i_core_clk);
        chk({o_halt, o_fatal_stop_code}, 32'h19f);
        results();
    end
endmodule
`default_nettype wire
